// ==== rtl/event_step_sequencer.v ====
// Sixteen-step event sequencer with an AHB-Lite register slave.
`timescale 1ns/1ns
`include "event_step_sequencer_defines.vh"

// Overview of operation
// - Entering a step drives its stored pattern, then samples that step's event.
// - An event step holds while event false; timer runs only while event true.
// - When the step count has elapsed, move to the next step with its pattern.
// - Each step may be timer-only, event-only or both; any subset of steps.
// - Four consecutive status counters: step count, timer, preset step, current step.
// - Completion flag sets when the cycle completes, clears on sequencer reset.
// - Counters hold step count, hundredth-second timer, preset step, current step.
// - Preset step changes only when software writes it.
// - Final step done sets flag, enters complete, keeps final pattern and step.
// - Start and jog are ignored while complete.
// - Complete ends only on reset or run exit; reset clears flag, loads preset.
// - Start acts only when reset is off; runs timer and watches events.
// - Start off with reset off and no jog edge freezes step, timer, counts and outputs.
// - Each jog rising edge advances one step whatever start is, reset off.
// - Reset beats start; held in preset step without timer or events.
// - Preset step is 1 to 16, loaded on reset and on non-retentive run entry.
// - Each step has its own count of timer ticks.
// - Each step has its own optional event, chosen among discrete points.
// - Outputs driven whenever in run mode, regardless of start or reset.
// - Non-retentive run entry zeroes counts, loads preset; retentive keeps all.
// - Retentive is the default configuration.
// - Jog advances a step and clears the timer; start continues at once.
// - Time base programmable from 0.01 s to 99.99 s, shared by all steps.
// - Evaluated once per scan; resolution no finer than the scan.
module event_step_sequencer #(
  parameter TICK_CYCLES = `HUNDREDTH_NS / `CLOCK_PERIOD_NS
) (
  input wire clock,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [15:0] eventInputs,
  output reg [15:0] stepOutputs,
  output wire completionFlagOut
);

  // One-hot sequencer states.
  localparam ST_HALT = 3'b001;
  localparam ST_ACTIVE = 3'b010;
  localparam ST_DONE = 3'b100;
  localparam integer TICK_LAST_FULL = TICK_CYCLES - 1;
  localparam [`TICK_CNT_WIDTH-1:0] TICK_LAST = TICK_LAST_FULL[`TICK_CNT_WIDTH-1:0];

  // Sequencer state, the four status counters and the step whose pattern is showing.
  reg [2:0] state;
  reg [13:0] stepTickCount;
  reg [13:0] timerValue;
  reg [4:0] presetStep;
  reg [4:0] currentStep;
  reg [4:0] tableStep;
  reg [4:0] shownStep;
  reg completionFlag;

  // Control register, time base, jog edge capture and the scan tick divider.
  reg [`CTRL_WIDTH-1:0] control;
  reg [13:0] timeBase;
  reg jogPrev;
  reg jogPending;
  reg [`TICK_CNT_WIDTH-1:0] tickCount;
  reg tick;

  // Bus side: latched address, write strobe and read data being prepared.
  reg [7:0] addrReg;
  reg writePending;
  reg [31:0] next_hrdata;

  // Results of one scan of the current step, from the combinational evaluator.
  reg [13:0] next_timer;
  reg [13:0] next_count;
  reg evalAdvance;

  // Registered read data of the two step tables.
  wire [`PATTERN_WIDTH-1:0] patternData;
  wire [`CFG_WIDTH-1:0] configData;
  wire [`CFG_WIDTH-1:0] nextConfigData;

  // Table regions are recognised by address bits 7:6 of the latched write address.
  function isRegion;
    input [7:0] addr;
    input [1:0] region;
    begin
      isRegion = (addr[7:6] == region);
    end
  endfunction

  // A step with no count and no event takes no part in the sequence.
  function stepUsed;
    input [`CFG_WIDTH-1:0] cfg;
    begin
      stepUsed = cfg[`CFG_EVENT_EN] || (cfg[`CFG_COUNT_MSB:0] != `COUNT_ZERO);
    end
  endfunction

  // Control register fields.
  wire startCtl = control[`CTRL_START];
  wire jogCtl = control[`CTRL_JOG];
  wire resetCtl = control[`CTRL_RESET];
  wire runMode = control[`CTRL_RUN];
  wire nonRetentive = control[`CTRL_NONRETENTIVE];

  // The table memory answers one cycle late, so evaluation waits until it caught up.
  wire tableFresh = (tableStep == currentStep);
  // Sampling waits until the step's own pattern stands on the outputs, so no step is
  // left before its outputs were shown, not even by a jog.
  wire stepShown = (shownStep == currentStep);
  wire [3:0] currentIdx = currentStep[3:0] - 4'h1;
  wire [3:0] nextIdx = currentStep[3:0];
  wire hasEvent = configData[`CFG_EVENT_EN];
  wire eventTrue = eventInputs[configData[`CFG_SEL_MSB:`CFG_SEL_LSB]];
  wire [13:0] stepCounts = configData[`CFG_COUNT_MSB:0];
  wire [14:0] timerInc = {1'b0, timerValue} + `COUNT_ONE;
  wire [14:0] countInc = {1'b0, stepTickCount} + `COUNT_ONE;
  // The last step or a step followed by an unused one ends the cycle.
  wire finalStep = (currentStep == `STEP_LAST) || !stepUsed(nextConfigData);
  wire jogRise = jogCtl && !jogPrev;
  wire jogGo = jogPending && stepShown;
  wire scanGo = tick && startCtl && stepShown && evalAdvance;

  // Bus signalling: the slave never stalls and always answers OKAY.
  wire addrPhase = hsel && hready && htrans[1];
  wire [4:0] wrStep = hwdata[4:0];
  wire [13:0] wrBase = hwdata[13:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign completionFlagOut = completionFlag;

  // Output patterns, one word per step; the look-ahead port is not needed here.
  step_table_mem #(.WIDTH(`PATTERN_WIDTH)) patternTable (
    .clock(clock),
    .writeEnable(writePending && isRegion(addrReg, `REGION_PATTERN)),
    .writeAddr(addrReg[5:2]),
    .writeData(hwdata[`PATTERN_WIDTH-1:0]),
    .readAddrA(currentIdx),
    .readDataA(patternData),
    .readAddrB(nextIdx),
    .readDataB()
  );

  // Step configuration; port B looks one step ahead for the final-step test.
  step_table_mem #(.WIDTH(`CFG_WIDTH)) configTable (
    .clock(clock),
    .writeEnable(writePending && isRegion(addrReg, `REGION_CONFIG)),
    .writeAddr(addrReg[5:2]),
    .writeData(hwdata[`CFG_WIDTH-1:0]),
    .readAddrA(currentIdx),
    .readDataA(configData),
    .readAddrB(nextIdx),
    .readDataB(nextConfigData)
  );

  // Hundredth-second tick divider; the tick is also the scan on which steps are judged.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tickCount <= {`TICK_CNT_WIDTH{1'b0}};
      tick <= 1'b0;
    end else if (tickCount == TICK_LAST) begin
      tickCount <= {`TICK_CNT_WIDTH{1'b0}};
      tick <= 1'b1;
    end else begin
      tickCount <= tickCount + {{(`TICK_CNT_WIDTH-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

  // One scan of the current step: event gate, timer, then step count.
  always @* begin
    next_timer = timerValue;
    next_count = stepTickCount;
    evalAdvance = 1'b0;
    if (hasEvent && !eventTrue) begin
      evalAdvance = 1'b0;
    end else if (stepCounts == `COUNT_ZERO) begin
      evalAdvance = 1'b1;
    end else if (timerInc >= {1'b0, timeBase}) begin
      next_timer = `COUNT_ZERO;
      next_count = countInc[13:0];
      if (countInc >= {1'b0, stepCounts}) begin
        evalAdvance = 1'b1;
      end
    end else begin
      next_timer = timerInc[13:0];
    end
  end

  // Main sequencer: run entry, reset, jog and timed or event steps.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_HALT;
      stepTickCount <= `COUNT_ZERO;
      timerValue <= `COUNT_ZERO;
      currentStep <= `STEP_FIRST;
      completionFlag <= 1'b0;
      jogPrev <= 1'b0;
      jogPending <= 1'b0;
      tableStep <= `STEP_FIRST;
    end else begin
      tableStep <= currentStep;
      jogPrev <= jogCtl;
      // A new edge that lands on the cycle a pending jog is served is kept.
      if (jogRise && !resetCtl && state == ST_ACTIVE) begin
        jogPending <= 1'b1;
      end else if (jogGo || state != ST_ACTIVE || resetCtl) begin
        jogPending <= 1'b0;
      end
      case (state)
        ST_HALT: begin
          // Program-to-run entry; only the non-retentive option reloads the counters.
          if (runMode) begin
            state <= ST_ACTIVE;
            completionFlag <= 1'b0;
            if (nonRetentive) begin
              stepTickCount <= `COUNT_ZERO;
              timerValue <= `COUNT_ZERO;
              currentStep <= presetStep;
            end
          end
        end
        ST_ACTIVE: begin
          // Reset beats jog and start; the step is held at the preset meanwhile.
          if (!runMode) begin
            state <= ST_HALT;
          end else if (resetCtl) begin
            currentStep <= presetStep;
            stepTickCount <= `COUNT_ZERO;
            timerValue <= `COUNT_ZERO;
            completionFlag <= 1'b0;
          end else if (jogGo || scanGo) begin
            stepTickCount <= `COUNT_ZERO;
            timerValue <= `COUNT_ZERO;
            if (finalStep) begin
              state <= ST_DONE;
              completionFlag <= 1'b1;
            end else begin
              currentStep <= currentStep + `STEP_FIRST;
            end
          end else if (tick && startCtl && stepShown) begin
            timerValue <= next_timer;
            stepTickCount <= next_count;
          end
        end
        ST_DONE: begin
          // Start and jog have no effect here; only reset or leaving run mode leaves.
          if (!runMode) begin
            state <= ST_HALT;
          end else if (resetCtl) begin
            state <= ST_ACTIVE;
            completionFlag <= 1'b0;
            currentStep <= presetStep;
            stepTickCount <= `COUNT_ZERO;
            timerValue <= `COUNT_ZERO;
          end
        end
        default: begin
          state <= ST_HALT;
        end
      endcase
    end
  end

  // Outputs follow the current step's pattern in run mode and rest low otherwise.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stepOutputs <= 16'h0000;
      shownStep <= `STEP_NONE;
    end else if (runMode && tableFresh) begin
      stepOutputs <= patternData;
      shownStep <= currentStep;
    end else if (!runMode) begin
      stepOutputs <= 16'h0000;
      shownStep <= `STEP_NONE;
    end
  end

  // Bus address phase: latch the write target and prepare read data.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      addrReg <= 8'h00;
      writePending <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      writePending <= addrPhase && hwrite;
      if (addrPhase) begin
        addrReg <= haddr[7:0];
      end
      if (addrPhase && !hwrite) begin
        hrdata <= next_hrdata;
      end
    end
  end

  // Read decode; table words and unmapped offsets read as zero.
  always @* begin
    next_hrdata = 32'h00000000;
    case (haddr[7:0])
      `ADDR_STEP_TICK_COUNT: next_hrdata = {18'h00000, stepTickCount};
      `ADDR_TIMER_VALUE: next_hrdata = {18'h00000, timerValue};
      `ADDR_PRESET_STEP: next_hrdata = {27'h0000000, presetStep};
      `ADDR_CURRENT_STEP: next_hrdata = {27'h0000000, currentStep};
      `ADDR_CONTROL: next_hrdata = {27'h0000000, control};
      `ADDR_STATUS: next_hrdata = {30'h00000000, state == ST_DONE, completionFlag};
      `ADDR_TIME_BASE: next_hrdata = {18'h00000, timeBase};
      default: next_hrdata = 32'h00000000;
    endcase
  end

  // Register writes in the data phase; out-of-range step or base values are dropped.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      control <= `CTRL_RESET_VALUE;
      presetStep <= `STEP_FIRST;
      timeBase <= `TIME_BASE_RESET;
    end else if (writePending) begin
      case (addrReg)
        `ADDR_CONTROL: control <= hwdata[`CTRL_WIDTH-1:0];
        `ADDR_PRESET_STEP: begin
          if (hwdata[31:5] == 27'h0000000 && wrStep >= `STEP_FIRST && wrStep <= `STEP_LAST) begin
            presetStep <= wrStep;
          end
        end
        `ADDR_TIME_BASE: begin
          if (hwdata[31:14] == 18'h00000 && wrBase != `COUNT_ZERO &&
              wrBase <= `TIME_BASE_MAX) begin
            timeBase <= wrBase;
          end
        end
        default: begin
          control <= control;
        end
      endcase
    end
  end

endmodule // event_step_sequencer

// ==== rtl/event_step_sequencer_defines.vh ====
// Shared constants of the event step sequencer: register map, fields, reset values, timing.
`ifndef EVENT_STEP_SEQUENCER_DEFINES_VH
`define EVENT_STEP_SEQUENCER_DEFINES_VH

// Byte offsets of the scalar registers (low address bits).
`define ADDR_STEP_TICK_COUNT 8'h00
`define ADDR_TIMER_VALUE 8'h04
`define ADDR_PRESET_STEP 8'h08
`define ADDR_CURRENT_STEP 8'h0C
`define ADDR_CONTROL 8'h10
`define ADDR_STATUS 8'h14
`define ADDR_TIME_BASE 8'h18
// Step table regions, selected by address bits 7:6; word index in bits 5:2.
`define REGION_PATTERN 2'h1
`define REGION_CONFIG 2'h2

// Control register bits.
`define CTRL_START 0
`define CTRL_JOG 1
`define CTRL_RESET 2
`define CTRL_RUN 3
`define CTRL_NONRETENTIVE 4
`define CTRL_WIDTH 5
`define CTRL_RESET_VALUE 5'h00

// Status register bits.
`define STAT_FLAG 0
`define STAT_COMPLETE 1

// Step configuration word layout.
`define CFG_COUNT_MSB 13
`define CFG_SEL_LSB 14
`define CFG_SEL_MSB 17
`define CFG_EVENT_EN 18
`define CFG_WIDTH 19
`define PATTERN_WIDTH 16

// Step numbers and counter values.
`define STEP_FIRST 5'h01
`define STEP_LAST 5'h10
`define STEP_NONE 5'h00
`define COUNT_ZERO 14'h0000
`define COUNT_ONE 15'h0001
`define TIME_BASE_RESET 14'h0001
`define TIME_BASE_MAX 14'h270F

// Timing: clock period and the hundredth-second tick, both in nanoseconds.
`define CLOCK_PERIOD_NS 50
`define HUNDREDTH_NS 10000000
`define TICK_CNT_WIDTH 18

`endif

// ==== rtl/step_table_mem.v ====
// Sixteen-entry step table memory with one write port and two registered read ports.
`timescale 1ns/1ns
module step_table_mem #(
  parameter WIDTH = 16
) (
  input wire clock,
  input wire writeEnable,
  input wire [3:0] writeAddr,
  input wire [WIDTH-1:0] writeData,
  input wire [3:0] readAddrA,
  output reg [WIDTH-1:0] readDataA,
  input wire [3:0] readAddrB,
  output reg [WIDTH-1:0] readDataB
);

  reg [WIDTH-1:0] words [0:15];

  // Storage is not reset; software loads the table before entering run mode.
  always @(posedge clock) begin
    if (writeEnable) begin
      words[writeAddr] <= writeData;
    end
    readDataA <= words[readAddrA];
    readDataB <= words[readAddrB];
  end

endmodule // step_table_mem

// ==== verification/ladder_points.sv ====
// Ladder-side model that holds the discrete points feeding the step events.
`timescale 1ns/1ns
module ladder_points (
  input wire clock,
  input wire sys_rst,
  input wire setPoint,
  input wire [3:0] pointSel,
  input wire pointLevel,
  output logic [15:0] eventInputs
);
  // Each point is a level that holds until the ladder side changes it.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      eventInputs <= 16'h0000;
    end else if (setPoint) begin
      eventInputs[pointSel] <= pointLevel;
    end
  end
endmodule // ladder_points

// ==== verification/sequencer_chk.sv ====
// Port checker of the event step sequencer, bound into its top module.
`timescale 1ns/1ns
`include "event_step_sequencer_defines.vh"
module sequencer_chk #(
  parameter TICK_CYCLES = 4
) (
  input wire clock,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [15:0] stepOutputs,
  input wire completionFlagOut
);
  logic wrPend;
  logic [7:0] wrAddr;
  logic [4:0] ctl;
  logic [7:0] quietCnt;
  logic [3:0] sinceRun;
  // The control register has no port, so it is mirrored from the writes seen on the bus.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      ctl <= 5'h00;
      sinceRun <= 4'hF;
    end else begin
      wrPend <= hsel && hready && htrans[1] && hwrite;
      wrAddr <= haddr[7:0];
      if (wrPend && wrAddr == `ADDR_CONTROL) begin
        ctl <= hwdata[4:0];
      end
      if (wrPend && wrAddr == `ADDR_CONTROL && hwdata[3] && !ctl[3]) begin
        sinceRun <= 4'h0;
      end else if (sinceRun != 4'hF) begin
        sinceRun <= sinceRun + 4'h1;
      end
    end
  end
  // Counts cycles in run with start, jog and reset all off; saturates to stay bounded.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      quietCnt <= 8'h00;
    end else if (!ctl[3] || ctl[2:0] != 3'h0) begin
      quietCnt <= 8'h00;
    end else if (quietCnt != 8'hFF) begin
      quietCnt <= quietCnt + 8'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence completeHeld;
    completionFlagOut && ctl[3] && !ctl[2];
  endsequence
  sequence resetHeld;
    ctl[2] [*6];
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered an error");
  reset_vals_a: assert property ($fell(sys_rst) |->
    stepOutputs == 16'h0000 && !completionFlagOut && hrdata == 32'h0)
    else $error("outputs not cleared by reset");
  out_idle_a: assert property (!ctl[3] [*6] |-> stepOutputs == 16'h0000)
    else $error("outputs driven outside run mode");
  freeze_out_a: assert property (quietCnt >= TICK_CYCLES + 4 |->
    $stable(stepOutputs) && $stable(completionFlagOut))
    else $error("outputs moved while start is off");
  done_hold_a: assert property (completeHeld [*3] |-> $stable(stepOutputs))
    else $error("outputs moved in the complete state");
  flag_set_a: assert property ($rose(completionFlagOut) |->
    ctl[3] && !ctl[2] && $stable(stepOutputs))
    else $error("flag rose with a step change or outside run");
  flag_clear_a: assert property ($fell(completionFlagOut) |->
    ctl[2] || sinceRun < 4'h8)
    else $error("flag cleared without reset or run entry");
  reset_hold_a: assert property (resetHeld |->
    !completionFlagOut && $stable(stepOutputs))
    else $error("sequencer moved while reset bit held");
endmodule // sequencer_chk
bind event_step_sequencer sequencer_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clock, .sys_rst,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .stepOutputs, .completionFlagOut);

// ==== verification/tb.sv ====
// Register-level testbench of the event step sequencer.
`timescale 1ns/1ns
`include "event_step_sequencer_defines.vh"
module tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic setPoint = 1'b0;
  logic [3:0] pointSel = 4'h0;
  logic pointLevel = 1'b0;
  wire hready;
  wire hresp;
  wire [31:0] hrdata;
  wire [15:0] eventInputs;
  wire [15:0] stepOutputs;
  wire completionFlagOut;
  logic [31:0] rd;
  logic [7:0] rAddr [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h40, 8'h80};
  logic [31:0] rExp [10] = '{0, 0, 1, 1, 0, 0, 1, 0, 0, 0};
  logic [31:0] cfgTab [6] = '{0, 32'h2, 32'h48000, 32'h4C001, 32'h1, 32'h1};
  int n_fail = 0;
  int compares = 0;
  // Clock at 20 MHz.
  always #25 clock = ~clock;
  event_step_sequencer #(.TICK_CYCLES(4)) dut_u (.clock, .sys_rst, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .eventInputs,
    .stepOutputs, .completionFlagOut);
  ladder_points pts_u (.clock, .sys_rst, .setPoint, .pointSel, .pointLevel, .eventInputs);
  task automatic end_sim();
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Bounded wait for the slave's ready at a rising edge.
  task automatic wait_rdy();
    int i;
    i = 0;
    @(posedge clock);
    while (hready !== 1'b1) begin
      i++;
      if (i > 50) begin
        n_fail++;
        end_sim();
      end
      @(posedge clock);
    end
  endtask
  // One single word transfer; read data is taken at the data-phase edge.
  task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rdchk(string n, logic [7:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  // Polls the current step; a step that never comes ends the run.
  task automatic wait_step(logic [31:0] e);
    for (int i = 0; i < 100; i++) begin
      xfer(1'b0, `ADDR_CURRENT_STEP, 32'h0);
      if (rd === e) break;
    end
    chk("current step", e, rd);
    if (rd !== e) end_sim();
  endtask
  task automatic point(logic [3:0] s, logic v);
    setPoint <= 1'b1;
    pointSel <= s;
    pointLevel <= v;
    @(posedge clock);
    setPoint <= 1'b0;
  endtask
  function automatic logic [31:0] pat(int k);
    return {16'h0, 4'h5, k[3:0], 4'hA, ~k[3:0]};
  endfunction
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 10; i++) rdchk("reset value", rAddr[i], rExp[i]);
    xfer(1'b1, `ADDR_PRESET_STEP, 32'h11);
    xfer(1'b1, `ADDR_PRESET_STEP, 32'h0);
    rdchk("preset range", `ADDR_PRESET_STEP, 32'h1);
    xfer(1'b1, `ADDR_TIME_BASE, 32'h270F);
    xfer(1'b1, `ADDR_TIME_BASE, 32'h2710);
    rdchk("time base max", `ADDR_TIME_BASE, 32'h270F);
    xfer(1'b1, `ADDR_TIME_BASE, 32'h1);
    xfer(1'b1, `ADDR_CURRENT_STEP, 32'h7);
    rdchk("current read only", `ADDR_CURRENT_STEP, 32'h1);
    for (int k = 1; k <= 16; k++) begin
      xfer(1'b1, 8'(8'h3C + 4 * k), pat(k));
      xfer(1'b1, 8'(8'h7C + 4 * k), k < 6 ? cfgTab[k] : 32'h0);
    end
    // Run without start: the pattern of the preset step shows and nothing moves.
    xfer(1'b1, `ADDR_CONTROL, 32'h18);
    repeat (6) @(posedge clock);
    chk("outputs step 1", pat(1), {16'h0, stepOutputs});
    repeat (30) @(posedge clock);
    rdchk("frozen step", `ADDR_CURRENT_STEP, 32'h1);
    xfer(1'b1, `ADDR_CONTROL, 32'h19);
    wait_step(2);
    repeat (40) @(posedge clock);
    rdchk("event held", `ADDR_CURRENT_STEP, 32'h2);
    point(4'h2, 1'b1);
    wait_step(3);
    repeat (40) @(posedge clock);
    rdchk("timed event held", `ADDR_CURRENT_STEP, 32'h3);
    point(4'h3, 1'b1);
    wait_step(5);
    repeat (20) @(posedge clock);
    rdchk("complete status", `ADDR_STATUS, 32'h3);
    chk("flag pin", 32'h1, {31'h0, completionFlagOut});
    rdchk("final step", `ADDR_CURRENT_STEP, 32'h5);
    chk("final outputs", pat(5), {16'h0, stepOutputs});
    xfer(1'b1, `ADDR_CONTROL, 32'h1B);
    xfer(1'b1, `ADDR_CONTROL, 32'h19);
    repeat (10) @(posedge clock);
    rdchk("jog in complete", `ADDR_CURRENT_STEP, 32'h5);
    xfer(1'b1, `ADDR_CONTROL, 32'h1D);
    repeat (20) @(posedge clock);
    rdchk("flag after reset", `ADDR_STATUS, 32'h0);
    chk("flag pin clear", 32'h0, {31'h0, completionFlagOut});
    rdchk("held at preset", `ADDR_CURRENT_STEP, 32'h1);
    for (int j = 2; j <= 3; j++) begin
      xfer(1'b1, `ADDR_CONTROL, 32'h1A);
      xfer(1'b1, `ADDR_CONTROL, 32'h18);
      wait_step(j);
    end
    rdchk("timer after jog", `ADDR_TIMER_VALUE, 32'h0);
    xfer(1'b1, `ADDR_PRESET_STEP, 32'h4);
    rdchk("preset written", `ADDR_PRESET_STEP, 32'h4);
    xfer(1'b1, `ADDR_CONTROL, 32'h0);
    repeat (6) @(posedge clock);
    chk("outputs off", 32'h0, {16'h0, stepOutputs});
    xfer(1'b1, `ADDR_CONTROL, 32'h8);
    repeat (6) @(posedge clock);
    rdchk("retained step", `ADDR_CURRENT_STEP, 32'h3);
    xfer(1'b1, `ADDR_CONTROL, 32'h0);
    xfer(1'b1, `ADDR_CONTROL, 32'h18);
    repeat (6) @(posedge clock);
    rdchk("preset loaded", `ADDR_CURRENT_STEP, 32'h4);
    chk("outputs step 4", pat(4), {16'h0, stepOutputs});
    end_sim();
  end
endmodule // tb
